// [hw/scan_timer_counter_unit.sv]
`include "scan_timer_params.svh"
// Contract
// - Counter decrements only on count input rising edge between evaluations.
// - Counter holds value when count input is steady or falling.
// - Counter done flag sets at zero and holds until cleared.
// - Clear rising edge reloads counter present value from preset.
// - No decrement while clear is on; counting resumes after release.
// - Counter value survives power loss and interlocked-off sections.
// - Timers reset when interlocked off and on power interruption.
// - Non-BCD preset raises error flag; execution continues.
// - Bad indirect word or out-of-range address raises error flag.
// - Fast timer works like standard timer with 0.01 s steps.
// - Fast preset 00.00 sets done immediately without timing.
// - Duplex configuration rejects fast timer numbers 048 to 511.
// - Standard timer preset limited to 999.9 seconds.
// - One-second clock pulse bit, half on, half off.
// - Standard timer starts on condition on, reloads on condition off.
// - Standard timer counts down in 0.1 second steps.
// - Timer done flag holds until condition off resets it.
module scan_timer_counter_unit
    import scan_timer_pkg::*;
#(
    parameter int UNITS = 512,
    parameter int STD_TICK = `STD_TICK_CYC,
    parameter int FAST_TICK = `FAST_TICK_CYC,
    parameter int PULSE_HALF = `PULSE_HALF_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_fail,
    input wire unit_req_t req,
    output unit_resp_t resp,
    input wire logic [8:0] read_number,
    output logic [15:0] read_present_value,
    output logic read_done_flag,
    output logic clock_pulse_1s
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed
    {
        logic [UNITS-1:0][15:0] pv;
        logic [UNITS-1:0] done;
        logic [UNITS-1:0] prev_cp;
        logic [UNITS-1:0] prev_clr;
        logic [UNITS-1:0] running;
        logic [UNITS-1:0] fast_unit;
        logic [UNITS-1:0] fast_credit;
        logic [UNITS-1:0] std_credit;
        logic [31:0] std_cnt;
        logic [31:0] fast_cnt;
        logic [31:0] pulse_cnt;
        logic pulse;
        unit_resp_t resp;
        logic [15:0] rd_pv;
        logic rd_done;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // BCD check of one word
    function automatic logic bcd_ok(input logic [15:0] w);
        bcd_ok = (w[3:0] < 4'hA) && (w[7:4] < 4'hA) && (w[11:8] < 4'hA) && (w[15:12] < 4'hA);
    endfunction

    // BCD decrement by one, zero stays zero
    function automatic logic [15:0] bcd_dec(input logic [15:0] w);
        logic [15:0] r;
        logic borrow;
        r = w;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (borrow)
            begin
                if (r[i*4 +: 4] == 4'h0)
                begin
                    r[i*4 +: 4] = 4'h9;
                end
                else
                begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        bcd_dec = (w == 16'h0000) ? 16'h0000 : r;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb
    begin
        logic std_tick;
        logic fast_tick;
        logic [8:0] n;
        logic [15:0] pre;
        logic err;
        logic cp_rise;
        logic clr_rise;
        std_tick = 1'b0;
        fast_tick = 1'b0;
        n = req.number;
        pre = req.preset_value;
        err = 1'b0;
        cp_rise = 1'b0;
        clr_rise = 1'b0;
        st_nxt = st_r;
        st_nxt.resp.valid = 1'b0;

        // Free-running time bases: 0.1 s, 0.01 s, and the 1 s pulse
        std_tick = (st_r.std_cnt == 32'(STD_TICK - 1));
        st_nxt.std_cnt = std_tick ? 32'h0 : st_r.std_cnt + 32'h1;
        fast_tick = (st_r.fast_cnt == 32'(FAST_TICK - 1));
        st_nxt.fast_cnt = fast_tick ? 32'h0 : st_r.fast_cnt + 32'h1;
        if (st_r.pulse_cnt == 32'(PULSE_HALF - 1))
        begin
            st_nxt.pulse_cnt = 32'h0;
            st_nxt.pulse = ~st_r.pulse;
        end
        else
        begin
            st_nxt.pulse_cnt = st_r.pulse_cnt + 32'h1;
        end

        // Ticks accrue per running timer; low-numbered fast timers also update between scans
        for (int i = 0; i < UNITS; i++)
        begin
            if (st_r.running[i] && std_tick)
            begin
                st_nxt.std_credit[i] = 1'b1;
            end
            if (st_r.running[i] && fast_tick)
            begin
                st_nxt.fast_credit[i] = 1'b1;
                // Only fast timers numbered up to 02F step between scans; standard timers keep the 0.1 s base
                if (st_r.fast_unit[i] && i <= int'(`FAST_NUMBER_LAST) && st_r.pv[i] != 16'h0000)
                begin
                    st_nxt.pv[i] = bcd_dec(st_r.pv[i]);
                    st_nxt.fast_credit[i] = 1'b0;
                    st_nxt.done[i] = (st_nxt.pv[i] == 16'h0000);
                end
            end
        end

        // Power interruption resets every running timer; counters keep state
        if (power_fail)
        begin
            for (int i = 0; i < UNITS; i++)
            begin
                if (st_r.running[i])
                begin
                    st_nxt.running[i] = 1'b0;
                    st_nxt.done[i] = 1'b0;
                end
            end
        end
        else if (req.eval)
        begin
            // Error checks on the preset, indirect address and duplex fast number
            err = !bcd_ok(pre);
            if (req.indirect && req.indirect_addr > `DATA_MEMORY_LAST)
            begin
                err = 1'b1;
            end
            if (req.kind == UNIT_STD && pre > `STD_PRESET_MAX)
            begin
                err = 1'b1;
            end
            if (req.kind == UNIT_FAST && req.duplex && n > `FAST_NUMBER_LAST)
            begin
                err = 1'b1;
            end
            unique case (req.kind)
                UNIT_STD, UNIT_FAST:
                begin
                    if (req.kind == UNIT_FAST && req.duplex && n > `FAST_NUMBER_LAST)
                    begin
                        st_nxt.running[n] = st_r.running[n];
                    end
                    else if (!req.exec_cond || !req.interlock_section)
                    begin
                        st_nxt.pv[n] = pre;
                        st_nxt.done[n] = 1'b0;
                        st_nxt.running[n] = 1'b0;
                        st_nxt.std_credit[n] = 1'b0;
                        st_nxt.fast_credit[n] = 1'b0;
                    end
                    else if (req.kind == UNIT_FAST && pre == 16'h0000)
                    begin
                        st_nxt.pv[n] = 16'h0000;
                        st_nxt.done[n] = 1'b1;
                    end
                    else if (!st_r.running[n])
                    begin
                        st_nxt.running[n] = 1'b1;
                        st_nxt.fast_unit[n] = (req.kind == UNIT_FAST);
                        st_nxt.pv[n] = pre;
                        st_nxt.done[n] = (pre == 16'h0000);
                        st_nxt.std_credit[n] = 1'b0;
                        st_nxt.fast_credit[n] = 1'b0;
                    end
                    else
                    begin
                        if ((req.kind == UNIT_STD && st_r.std_credit[n])
                            || (req.kind == UNIT_FAST && st_r.fast_credit[n]))
                        begin
                            st_nxt.pv[n] = bcd_dec(st_r.pv[n]);
                        end
                        st_nxt.std_credit[n] = 1'b0;
                        st_nxt.fast_credit[n] = 1'b0;
                        st_nxt.done[n] = st_r.done[n] || (st_nxt.pv[n] == 16'h0000);
                    end
                end
                UNIT_COUNTER:
                begin
                    // Interlocked off: nothing changes, value retained
                    if (req.interlock_section)
                    begin
                        cp_rise = req.count_pulse_input && !st_r.prev_cp[n];
                        clr_rise = req.clear_in && !st_r.prev_clr[n];
                        st_nxt.prev_cp[n] = req.count_pulse_input;
                        st_nxt.prev_clr[n] = req.clear_in;
                        if (clr_rise)
                        begin
                            st_nxt.pv[n] = pre;
                            st_nxt.done[n] = (pre == 16'h0000);
                        end
                        else if (req.clear_in)
                        begin
                            st_nxt.pv[n] = st_r.pv[n];
                        end
                        else if (cp_rise && st_r.pv[n] != 16'h0000)
                        begin
                            st_nxt.pv[n] = bcd_dec(st_r.pv[n]);
                            st_nxt.done[n] = (st_nxt.pv[n] == 16'h0000);
                        end
                    end
                end
                default:
                begin
                    err = 1'b1;
                end
            endcase
            st_nxt.resp.valid = 1'b1;
            st_nxt.resp.present_value = st_nxt.pv[n];
            st_nxt.resp.done_flag = st_nxt.done[n];
            st_nxt.resp.error_flag = err;
        end

        // Readback of any number
        st_nxt.rd_pv = st_r.pv[read_number];
        st_nxt.rd_done = st_r.done[read_number];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs from the state register
    assign resp = st_r.resp;
    assign read_present_value = st_r.rd_pv;
    assign read_done_flag = st_r.rd_done;
    assign clock_pulse_1s = st_r.pulse;

endmodule

// [hw/scan_timer_params.svh]
`ifndef SCAN_TIMER_PARAMS_SVH
`define SCAN_TIMER_PARAMS_SVH
// ----------------------------------------
// Timing constants
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define STD_TICK_MS 100
`define FAST_TICK_MS 10
`define PULSE_HALF_MS 500
`define STD_TICK_CYC ((`STD_TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define FAST_TICK_CYC ((`FAST_TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define PULSE_HALF_CYC ((`PULSE_HALF_MS * 1000000) / `CLK_PERIOD_NS)
// ----------------------------------------
// Preset limits and numbering
// ----------------------------------------
`define STD_PRESET_MAX 16'h9999
`define FAST_NUMBER_LAST 9'h02F
`define NUMBER_LAST 9'h1FF
`define DATA_MEMORY_LAST 16'h1FFF
`define PV_RESET 16'h0000
`endif

// [hw/scan_timer_pkg.sv]
package scan_timer_pkg;
    // Kind of unit evaluated in a scan step
    typedef enum logic [2:0]
    {
        UNIT_STD = 3'b001,
        UNIT_FAST = 3'b010,
        UNIT_COUNTER = 3'b100
    } unit_kind_t;

    // One evaluation request from the scan engine
    typedef struct packed
    {
        logic eval;
        unit_kind_t kind;
        logic [8:0] number;
        logic [15:0] preset_value;
        logic exec_cond;
        logic count_pulse_input;
        logic clear_in;
        logic interlock_section;
        logic indirect;
        logic [15:0] indirect_addr;
        logic duplex;
    } unit_req_t;

    // Answer to the scan engine
    typedef struct packed
    {
        logic valid;
        logic [15:0] present_value;
        logic done_flag;
        logic error_flag;
    } unit_resp_t;
endpackage

// [test/scan_timer_counter_unit_asserts.sv]
module scan_timer_counter_unit_asserts
    import scan_timer_pkg::*;
#(
    parameter int PULSE_HALF = 20
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic power_fail,
    input wire unit_req_t req,
    input wire unit_resp_t resp,
    input wire logic [8:0] read_number,
    input wire logic [15:0] read_present_value,
    input wire logic read_done_flag,
    input wire logic clock_pulse_1s
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic tk;
    logic tmr;
    logic bad;
    logic bcd;
    logic [31:0] cyc_r;
    // Request classes seen at the taking edge
    assign tk = req.eval && !power_fail;
    assign tmr = req.kind != UNIT_COUNTER;
    assign bad = req.kind == UNIT_FAST && req.duplex && req.number > 9'h02F;
    assign bcd = req.preset_value[15:12] < 4'hA && req.preset_value[11:8] < 4'hA
        && req.preset_value[7:4] < 4'hA && req.preset_value[3:0] < 4'hA;
    // Cycles since the pulse bit last moved
    always_ff @(posedge clk)
    begin
        cyc_r <= rst ? 32'h0 : ($changed(clock_pulse_1s) ? 32'h1 : cyc_r + 32'h1);
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_answer_latency: assert property (tk |=> resp.valid)
        else $error("no answer one cycle after request");
    a_no_stray_answer: assert property (!tk |=> !resp.valid)
        else $error("answer without a taken request");
    a_timer_reload: assert property (tk && tmr && !bad && !req.exec_cond
        |=> resp.present_value == $past(req.preset_value) && !resp.done_flag)
        else $error("timer not reloaded with condition off");
    a_interlock_reset: assert property (tk && tmr && !bad && !req.interlock_section
        |=> resp.present_value == $past(req.preset_value) && !resp.done_flag)
        else $error("timer not reset in interlocked section");
    a_clear_holds: assert property (tk && req.kind == UNIT_COUNTER && req.clear_in
        && req.interlock_section |=> resp.present_value == $past(req.preset_value))
        else $error("counter moved while clear on");
    a_fast_zero: assert property (tk && req.kind == UNIT_FAST && !bad && req.exec_cond
        && req.interlock_section && req.preset_value == 16'h0000 |=> resp.done_flag)
        else $error("zero fast preset not done at once");
    a_duplex_reject: assert property (tk && bad |=> resp.error_flag)
        else $error("high fast number accepted in duplex");
    a_nonbcd_error: assert property (tk && !bcd |=> resp.error_flag)
        else $error("non-BCD preset without error");
    a_indirect_range: assert property (tk && req.indirect && req.indirect_addr > 16'h1FFF
        |=> resp.error_flag)
        else $error("indirect address past end without error");
    a_pulse_period: assert property (cyc_r <= PULSE_HALF)
        else $error("pulse bit half period too long");
    a_pulse_steady: assert property ($changed(clock_pulse_1s) |=> $stable(clock_pulse_1s)[*8])
        else $error("pulse bit half period too short");
endmodule

// [test/scan_engine_model.sv]
module scan_engine_model
    import scan_timer_pkg::*;
(
    input wire logic clk,
    input wire unit_resp_t resp,
    output unit_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // One evaluation; presets stay BCD unless a refusal is meant
    task automatic issue(output unit_resp_t r, input unit_kind_t k, input logic [8:0] n,
        input logic [15:0] p, input logic ex, cp, cl, il, input logic ind = 1'b0,
        input logic [15:0] a = 16'h0000, input logic dup = 1'b0);
        @(posedge clk);
        req <= '{1'b1, k, n, p, ex, cp, cl, il, ind, a, dup};
        @(posedge clk);
        req.eval <= 1'b0;
        #1;
        r = resp;
    endtask
endmodule

// [test/scan_timer_counter_unit_tb_top.sv]
module scan_timer_counter_unit_tb_top
    import scan_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ST = 10;
    localparam int PH = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_fail = 1'b0;
    logic [8:0] read_number = 9'h000;
    unit_req_t req;
    unit_resp_t resp;
    unit_resp_t r;
    logic [15:0] rpv;
    logic rdf;
    logic cp1;
    logic pulse_was;
    int n_errors = 0;
    int compares = 0;
    always #2 clk = ~clk;
    scan_timer_counter_unit #(.STD_TICK(ST), .FAST_TICK(3), .PULSE_HALF(PH)) i_scan_timer_counter_unit (
        .clk(clk), .rst(rst), .power_fail(power_fail), .req(req), .resp(resp), .read_number(read_number),
        .read_present_value(rpv), .read_done_flag(rdf), .clock_pulse_1s(cp1));
    scan_engine_model i_scan_engine_model (.clk(clk), .resp(resp), .req(req));
    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic chk16(input string w, input logic [15:0] e, g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk1(input string w, input logic e, g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", w, e, g);
        end
    endtask
    task automatic op(input unit_kind_t k, input logic [8:0] n, input logic [15:0] p,
        input logic ex, cp, cl, il, input logic [15:0] epv, input logic ed);
        i_scan_engine_model.issue(r, k, n, p, ex, cp, cl, il);
        chk1("valid", 1'b1, r.valid);
        chk16("present", epv, r.present_value);
        chk1("done", ed, r.done_flag);
    endtask
    task automatic err(input unit_kind_t k, input logic [8:0] n, input logic [15:0] p, a,
        input logic ind, dup, ee);
        i_scan_engine_model.issue(r, k, n, p, 1'b1, 1'b0, 1'b0, 1'b1, ind, a, dup);
        chk1("error", ee, r.error_flag);
    endtask
    task automatic rd(input logic [8:0] n, input logic [15:0] epv, input logic ed);
        @(posedge clk);
        read_number <= n;
        @(posedge clk);
        #1;
        chk16("read value", epv, rpv);
        chk1("read done", ed, rdf);
    endtask
    task automatic pfail();
        @(posedge clk);
        power_fail <= 1'b1;
        repeat (3) @(posedge clk);
        power_fail <= 1'b0;
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Counter: clear, hold, count to zero, keep through power loss
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0003, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b1, 1'b1, 16'h0003, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0003, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0002, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0002, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0002, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0001, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0001, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0001, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0001, 1'b0);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0000, 1'b1);
        op(UNIT_COUNTER, 9'h0C8, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1);
        pfail();
        rd(9'h0C8, 16'h0000, 1'b1);
        // Standard timer: BCD steps, completion, reset
        op(UNIT_STD, 9'h064, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0010, 1'b0);
        repeat (ST + 2) @(posedge clk);
        op(UNIT_STD, 9'h064, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0009, 1'b0);
        op(UNIT_STD, 9'h064, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0010, 1'b0);
        op(UNIT_STD, 9'h065, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0001, 1'b0);
        repeat (ST + 2) @(posedge clk);
        op(UNIT_STD, 9'h065, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1);
        repeat (ST + 2) @(posedge clk);
        op(UNIT_STD, 9'h065, 16'h0001, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1);
        pfail();
        rd(9'h065, 16'h0000, 1'b0);
        op(UNIT_STD, 9'h065, 16'h0001, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001, 1'b0);
        op(UNIT_STD, 9'h066, 16'h9999, 1'b1, 1'b0, 1'b0, 1'b1, 16'h9999, 1'b0);
        // Fast timer
        op(UNIT_FAST, 9'h003, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0000, 1'b1);
        op(UNIT_FAST, 9'h004, 16'h0050, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0050, 1'b0);
        // Standard timer on a low number must not take the fast base
        op(UNIT_STD, 9'h005, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0010, 1'b0);
        repeat (ST + 2) @(posedge clk);
        op(UNIT_STD, 9'h005, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0009, 1'b0);
        // Fast timer on a high number steps once per scan with a tick
        op(UNIT_FAST, 9'h040, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0010, 1'b0);
        repeat (4) @(posedge clk);
        op(UNIT_FAST, 9'h040, 16'h0010, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0009, 1'b0);
        // Error reporting
        err(UNIT_COUNTER, 9'h0C9, 16'h00A1, 16'h0000, 1'b0, 1'b0, 1'b1);
        err(UNIT_STD, 9'h067, 16'h0005, 16'h2000, 1'b1, 1'b0, 1'b1);
        err(UNIT_STD, 9'h067, 16'h0005, 16'h1FFF, 1'b1, 1'b0, 1'b0);
        err(UNIT_FAST, 9'h030, 16'h0005, 16'h0000, 1'b0, 1'b1, 1'b1);
        err(UNIT_FAST, 9'h02F, 16'h0005, 16'h0000, 1'b0, 1'b1, 1'b0);
        // Pulse bit inverts every half period
        @(posedge clk);
        #1;
        pulse_was = cp1;
        repeat (PH) @(posedge clk);
        #1;
        chk1("pulse", ~pulse_was, cp1);
        test_done();
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule
bind scan_timer_counter_unit scan_timer_counter_unit_asserts #(.PULSE_HALF(PULSE_HALF)) i_asserts (
    .clk(clk), .rst(rst), .power_fail(power_fail), .req(req), .resp(resp), .read_number(read_number),
    .read_present_value(read_present_value), .read_done_flag(read_done_flag), .clock_pulse_1s(clock_pulse_1s));
